// >>> rtl/boot_params.svh
// Constants for the serial boot command protocol block.
`ifndef BOOT_PARAMS_SVH
`define BOOT_PARAMS_SVH

`define MODE_UART_BYTE 8'h86
`define MODE_SYNC_BYTE 8'h30
`define CMD_RAM_LOAD 8'h10
`define CMD_FLASH_SUM 8'h20
`define CMD_PRODUCT_INFO 8'h30
`define ACK_OK 8'h10
`define ACK_BAD_SUM 8'h11
`define ACK_COMM_ERR 8'h18
`define NIB_NEG 4'h1
`define NIB_ERR 4'h8
`define PASS_LEN 16'h000D
`define HDR_LEN 16'h0007
`define FSUM_LEN 16'h0003
`define BAUD_MIN_CYC 16'h0004
`define BAUD_MAX_CYC 20'hFFFFF
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16

`endif

// >>> rtl/boot_pkg.sv
// Types shared by the serial boot command protocol block.
package boot_pkg;

	typedef enum logic [12:0] {
		ST_BOOT  = 13'h0001,
		ST_BAUD  = 13'h0002,
		ST_SKIP  = 13'h0004,
		ST_SEND  = 13'h0008,
		ST_SENDW = 13'h0010,
		ST_CMD   = 13'h0020,
		ST_PASS  = 13'h0040,
		ST_HDR   = 13'h0080,
		ST_DATA  = 13'h0100,
		ST_FSUM  = 13'h0200,
		ST_JUMP  = 13'h0400,
		ST_RUN   = 13'h0800,
		ST_ABORT = 13'h1000
	} eng_state_e;

	typedef enum logic [2:0] {
		LINK_NONE = 3'h1,
		LINK_UART = 3'h2,
		LINK_SYNC = 3'h4
	} link_mode_e;

endpackage

// >>> rtl/byte_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_q;
	logic [AW:0] rd_ptr_q;

	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	wire ptr_same = wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0];

	assign in_ready = ~(ptr_same & (wr_ptr_q[AW] != rd_ptr_q[AW]));
	assign out_valid = wr_ptr_q != rd_ptr_q;
	assign out_data = mem[rd_ptr_q[AW-1:0]];

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end
endmodule

// >>> rtl/serial_boot_command_protocol.sv
// Boot command interpreter on the boot serial channel, asynchronous or clocked.
//
// Summary of operation
// - Command codes 10H, 20H and 30H are decoded; 30H is answered negatively here.
// - Device acknowledges header checksum with 10H, 11H or 18H.
// - Data bytes then their checksum; device acknowledges with 10H, 11H or 18H.
// - After a good data acknowledge the device jumps to the start address.
// - Any negative acknowledge returns the device to waiting for a command.
// - Clocked mode suppresses the negative acknowledge on a communication error.
// - Mode byte 86H or 30H is echoed back as acknowledge.
// - Asynchronous mode aborts silently when the baud rate cannot be set.
// - Flash sum command 20H acknowledged 20H, x1H negative, x8H error.
// - Flash sum sent upper byte, lower byte, then their checksum.
// - After the flash sum checksum the device waits for the next command.
`timescale 1ns/1ps
`include "boot_params.svh"
module serial_boot_command_protocol
	import boot_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic boot_serial_channel_rxd,
	output logic boot_serial_channel_txd,
	input wire logic serial_shift_clock,
	output logic boot_ready,
	input wire logic [15:0] flash_sum,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic jump_en,
	output logic [31:0] jump_addr,
	output logic boot_abort,
	output logic sync_mode
);
	logic rxd_s1_q, rxd_s2_q, rxd_prev_q;
	logic sck_s1_q, sck_s2_q, sck_prev_q;
	eng_state_e state_q, ret_q;
	link_mode_e mode_q;
	logic [19:0] cnt_q;
	logic [15:0] bit_q;
	logic baud_set_q;
	logic [7:0] send_q;
	logic [15:0] idx_q;
	logic [7:0] sum_q;
	logic [47:0] hdr_q;
	logic [15:0] fs_q;
	logic err_q;
	logic rx_busy_q, rx_push_q, rx_ferr_q;
	logic [15:0] rx_cnt_q;
	logic [3:0] rx_idx_q;
	logic [7:0] rx_sh_q;
	logic tx_start_q, tx_busy_q, txd_q;
	logic [8:0] tx_sh_q;
	logic [3:0] tx_bits_q;
	logic [15:0] tx_cnt_q;
	logic ready_q, mem_we_q, jump_q, abort_q, sync_q;
	logic [31:0] mem_addr_q, jump_addr_q;
	logic [7:0] mem_wdata_q;
	logic fifo_in_ready, fifo_out_valid;
	logic [7:0] fifo_out_data;

	// Edge detection compares the second synchroniser stage with its delayed copy.
	wire rxd_fall = rxd_prev_q & ~rxd_s2_q;
	wire sck_rise = ~sck_prev_q & sck_s2_q;
	wire sck_fall = sck_prev_q & ~sck_s2_q;
	wire is_sync = mode_q == LINK_SYNC;
	wire is_uart = mode_q == LINK_UART;

	wire eng_rx = (state_q == ST_BOOT && is_sync) || state_q == ST_CMD || state_q == ST_PASS ||
		state_q == ST_HDR || state_q == ST_DATA;
	wire got = fifo_out_valid & eng_rx;
	wire [7:0] b = fifo_out_data;
	wire [31:0] start_addr = hdr_q[47:16];
	wire [15:0] byte_count = hdr_q[15:0];
	wire [15:0] idx_inc = idx_q + 16'h0001;

	wire [7:0] sum_next = sum_q + b;
	wire sum_ok = sum_next == 8'h00;

	wire last_byte = (state_q == ST_PASS && idx_inc == `PASS_LEN) ||
		(state_q == ST_HDR && idx_inc == `HDR_LEN) ||
		(state_q == ST_DATA && idx_q == byte_count);
	wire eng_state_e ok_next = (state_q == ST_PASS) ? ST_HDR : (state_q == ST_HDR) ? ST_DATA : ST_JUMP;
	wire [7:0] ack_code = err_q ? `ACK_COMM_ERR : (sum_ok ? `ACK_OK : `ACK_BAD_SUM);
	// No answer on error in clocked mode.
	wire drop_ack = err_q & is_sync;
	wire err_clr = got & (state_q == ST_CMD || last_byte);
	wire rx_err = rx_ferr_q | (rx_push_q & ~fifo_in_ready);

	wire [7:0] fs_ck = 8'h00 - (fs_q[15:8] + fs_q[7:0]);
	wire [7:0] fsum_byte = (idx_q == 16'h0000) ? fs_q[15:8] : (idx_q == 16'h0001) ? fs_q[7:0] : fs_ck;

	wire [19:0] skip_end = {1'b0, bit_q, 3'b000} - {5'h00, bit_q[15:1]};
	wire [15:0] meas_bit = cnt_q[16:1];
	wire uart_rx_en = is_uart & baud_set_q;
	wire sync_rx_en = is_sync & ~tx_busy_q & ~tx_start_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
			rxd_prev_q <= 1'b1;
			sck_s1_q <= 1'b1;
			sck_s2_q <= 1'b1;
			sck_prev_q <= 1'b1;
		end else begin
			rxd_s1_q <= boot_serial_channel_rxd;
			rxd_s2_q <= rxd_s1_q;
			rxd_prev_q <= rxd_s2_q;
			sck_s1_q <= serial_shift_clock;
			sck_s2_q <= sck_s1_q;
			sck_prev_q <= sck_s2_q;
		end
	end

	// Sticky communication error; a new error wins over the clear.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			err_q <= 1'b0;
		end else begin
			err_q <= rx_err | (err_q & ~err_clr);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q <= ST_BOOT;
			ret_q <= ST_CMD;
			mode_q <= LINK_NONE;
			cnt_q <= 20'h00000;
			bit_q <= 16'h0000;
			baud_set_q <= 1'b0;
			send_q <= 8'h00;
			idx_q <= 16'h0000;
			sum_q <= 8'h00;
			hdr_q <= 48'h000000000000;
			fs_q <= 16'h0000;
			tx_start_q <= 1'b0;
		end else begin
			tx_start_q <= 1'b0;
			case (state_q)
				ST_BOOT: begin
					if (mode_q == LINK_NONE && sck_fall) begin
						mode_q <= LINK_SYNC;
					end else if (mode_q == LINK_NONE && rxd_fall) begin
						mode_q <= LINK_UART;
						cnt_q <= 20'h00000;
						state_q <= ST_BAUD;
					end else if (got && b == `MODE_SYNC_BYTE) begin
						send_q <= `MODE_SYNC_BYTE;
						ret_q <= ST_CMD;
						state_q <= ST_SEND;
					end
				end
				ST_BAUD: begin
					cnt_q <= cnt_q + 20'h00001;
					if (cnt_q == `BAUD_MAX_CYC) begin
						state_q <= ST_ABORT;
					end else if (rxd_s2_q) begin
						bit_q <= meas_bit;
						cnt_q <= 20'h00000;
						state_q <= (meas_bit < `BAUD_MIN_CYC) ? ST_ABORT : ST_SKIP;
					end
				end
				ST_SKIP: begin
					cnt_q <= cnt_q + 20'h00001;
					if (cnt_q >= skip_end) begin
						baud_set_q <= 1'b1;
						send_q <= `MODE_UART_BYTE;
						ret_q <= ST_CMD;
						state_q <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (!tx_busy_q) begin
						tx_start_q <= 1'b1;
						state_q <= ST_SENDW;
					end
				end
				ST_SENDW: begin
					if (!tx_start_q && !tx_busy_q) begin
						state_q <= ret_q;
					end
				end
				ST_CMD: begin
					if (got) begin
						idx_q <= 16'h0000;
						sum_q <= 8'h00;
						state_q <= ST_SEND;
						ret_q <= ST_CMD;
						if (drop_ack) begin
							state_q <= ST_CMD;
						end else if (err_q) begin
							send_q <= {b[7:4], `NIB_ERR};
						end else if (b == `CMD_RAM_LOAD) begin
							send_q <= `ACK_OK;
							ret_q <= ST_PASS;
						end else if (b == `CMD_FLASH_SUM) begin
							send_q <= `CMD_FLASH_SUM;
							fs_q <= flash_sum;
							ret_q <= ST_FSUM;
						end else begin
							send_q <= {b[7:4], `NIB_NEG};
						end
					end
				end
				ST_PASS, ST_HDR, ST_DATA: begin
					if (got && last_byte) begin
						idx_q <= 16'h0000;
						sum_q <= 8'h00;
						send_q <= ack_code;
						// Negative acknowledge returns to command wait.
						ret_q <= (err_q || !sum_ok) ? ST_CMD : ok_next;
						state_q <= drop_ack ? ST_CMD : ST_SEND;
					end else if (got) begin
						idx_q <= idx_inc;
						sum_q <= sum_next;
						if (state_q == ST_HDR) begin
							hdr_q <= {hdr_q[39:0], b};
						end
					end
				end
				ST_FSUM: begin
					if (idx_q == `FSUM_LEN) begin
						state_q <= ST_CMD;
					end else begin
						send_q <= fsum_byte;
						idx_q <= idx_inc;
						ret_q <= ST_FSUM;
						state_q <= ST_SEND;
					end
				end
				ST_JUMP: begin
					state_q <= ST_RUN;
				end
				ST_RUN, ST_ABORT: begin
					state_q <= state_q;
				end
				default: begin
					state_q <= ST_BOOT;
				end
			endcase
		end
	end

	// Receiver: asynchronous frames at the measured rate, or clocked bits on shift clock rises.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_busy_q <= 1'b0;
			rx_cnt_q <= 16'h0000;
			rx_idx_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_push_q <= 1'b0;
			rx_ferr_q <= 1'b0;
		end else begin
			rx_push_q <= 1'b0;
			rx_ferr_q <= 1'b0;
			if (sync_rx_en && sck_rise) begin
				rx_sh_q <= {rxd_s2_q, rx_sh_q[7:1]};
				rx_idx_q <= (rx_idx_q == 4'h7) ? 4'h0 : rx_idx_q + 4'h1;
				rx_push_q <= rx_idx_q == 4'h7;
			end else if (!rx_busy_q) begin
				if (uart_rx_en && rxd_fall) begin
					rx_busy_q <= 1'b1;
					rx_cnt_q <= {1'b0, bit_q[15:1]};
					rx_idx_q <= 4'h0;
				end
			end else if (rx_cnt_q != 16'h0000) begin
				rx_cnt_q <= rx_cnt_q - 16'h0001;
			end else begin
				rx_cnt_q <= bit_q - 16'h0001;
				rx_idx_q <= rx_idx_q + 4'h1;
				if (rx_idx_q == 4'h0) begin
					rx_busy_q <= ~rxd_s2_q;
				end else if (rx_idx_q <= 4'h8) begin
					rx_sh_q <= {rxd_s2_q, rx_sh_q[7:1]};
				end else begin
					rx_busy_q <= 1'b0;
					rx_push_q <= rxd_s2_q;
					rx_ferr_q <= ~rxd_s2_q;
				end
			end
		end
	end

	// Transmitter: asynchronous frame or clocked bits on shift clock falls.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_busy_q <= 1'b0;
			tx_sh_q <= 9'h1FF;
			tx_bits_q <= 4'h0;
			tx_cnt_q <= 16'h0000;
			txd_q <= 1'b1;
		end else if (tx_start_q) begin
			tx_busy_q <= 1'b1;
			tx_sh_q <= {1'b1, send_q};
			tx_bits_q <= is_sync ? 4'h8 : 4'h9;
			tx_cnt_q <= bit_q - 16'h0001;
			txd_q <= is_sync;
		end else if (tx_busy_q && is_sync) begin
			if (sck_fall && tx_bits_q != 4'h0) begin
				txd_q <= tx_sh_q[0];
				tx_sh_q <= {1'b1, tx_sh_q[8:1]};
				tx_bits_q <= tx_bits_q - 4'h1;
			end else if (sck_rise && tx_bits_q == 4'h0) begin
				tx_busy_q <= 1'b0;
				txd_q <= 1'b1;
			end
		end else if (tx_busy_q) begin
			if (tx_cnt_q != 16'h0000) begin
				tx_cnt_q <= tx_cnt_q - 16'h0001;
			end else if (tx_bits_q == 4'h0) begin
				tx_busy_q <= 1'b0;
			end else begin
				tx_cnt_q <= bit_q - 16'h0001;
				txd_q <= tx_sh_q[0];
				tx_sh_q <= {1'b1, tx_sh_q[8:1]};
				tx_bits_q <= tx_bits_q - 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ready_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= 32'h00000000;
			mem_wdata_q <= 8'h00;
			jump_q <= 1'b0;
			jump_addr_q <= 32'h00000000;
			abort_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			ready_q <= is_sync & fifo_in_ready & ~tx_busy_q & ~tx_start_q;
			mem_we_q <= got & (state_q == ST_DATA) & ~last_byte;
			mem_addr_q <= start_addr + {16'h0000, idx_q};
			mem_wdata_q <= b;
			jump_q <= state_q == ST_JUMP;
			jump_addr_q <= start_addr;
			abort_q <= state_q == ST_ABORT;
			sync_q <= baud_set_q | is_sync;
		end
	end

	byte_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH)
	) rx_fifo (
		.ref_clk(ref_clk),
		.srst(srst),
		.in_valid(rx_push_q),
		.in_ready(fifo_in_ready),
		.in_data(rx_sh_q),
		.out_valid(fifo_out_valid),
		.out_ready(eng_rx),
		.out_data(fifo_out_data)
	);

	assign boot_serial_channel_txd = txd_q;
	assign boot_ready = ready_q;
	assign mem_we = mem_we_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign jump_en = jump_q;
	assign jump_addr = jump_addr_q;
	assign boot_abort = abort_q;
	assign sync_mode = sync_q;
endmodule

// >>> tb/boot_host_model.sv
// Host controller model for the clocked boot channel.
`timescale 1ns/1ps
module boot_host_model (
	input wire logic ref_clk,
	input wire logic txd,
	input wire logic boot_ready,
	output logic rxd,
	output logic shift_clk
);
	int half = 64;
	initial begin
		rxd = 1'b1;
		shift_clk = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic send_byte(input logic [7:0] b);
		int n = 0;
		while (half < 64 && !boot_ready && n < 2000) begin
			tick(1);
			n++;
		end
		for (int i = 0; i < 8; i++) begin
			shift_clk = 1'b0;
			tick(1);
			rxd = b[i];
			tick(half - 1);
			shift_clk = 1'b1;
			tick(half);
		end
		// Data line has a pull-up once released.
		rxd = 1'b1;
	endtask
	task automatic recv_byte(output logic [7:0] b);
		int n = 0;
		tick(8);
		while (boot_ready && n < 2000) begin
			tick(1);
			n++;
		end
		for (int i = 0; i < 8; i++) begin
			shift_clk = 1'b0;
			tick(half);
			b[i] = txd;
			shift_clk = 1'b1;
			if (i < 7) tick(half);
		end
	endtask
endmodule

// >>> tb/serial_boot_assertions.sv
// Port checker for the boot command interpreter.
`timescale 1ns/1ps
module boot_checker (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic boot_serial_channel_txd,
	input wire logic boot_ready,
	input wire logic mem_we,
	input wire logic jump_en,
	input wire logic [31:0] jump_addr,
	input wire logic boot_abort,
	input wire logic sync_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// For eight cycles after the jump the block must not write or jump again.
	sequence s_quiet;
		(!mem_we && !jump_en)[*8];
	endsequence
	sequence s_addr_held;
		$stable(jump_addr)[*8];
	endsequence
	chk_we_pulse: assert property (mem_we |=> !mem_we) else $error("write strobe too long");
	chk_jump_pulse: assert property (jump_en |=> !jump_en) else $error("jump strobe too long");
	chk_jump_idle: assert property (jump_en |=> s_quiet) else $error("activity after jump");
	chk_jump_hold: assert property (jump_en |=> s_addr_held) else $error("jump address moved");
	chk_jump_mode: assert property (jump_en |-> sync_mode && !boot_abort) else $error("jump without session");
	chk_abort_hold: assert property (boot_abort |=> boot_abort) else $error("abort released");
	chk_abort_quiet: assert property (boot_abort |-> boot_serial_channel_txd && !sync_mode)
		else $error("aborted device talks");
	chk_mode_hold: assert property (sync_mode |=> sync_mode) else $error("mode lost");
	chk_ready_tx: assert property (!boot_serial_channel_txd && sync_mode |-> !boot_ready)
		else $error("ready while sending");
endmodule
bind serial_boot_command_protocol boot_checker chk (.ref_clk(ref_clk), .srst(srst),
	.boot_serial_channel_txd(boot_serial_channel_txd), .boot_ready(boot_ready), .mem_we(mem_we),
	.jump_en(jump_en), .jump_addr(jump_addr), .boot_abort(boot_abort), .sync_mode(sync_mode));

// >>> tb/serial_boot_command_protocol_test.sv
// Self-checking bench for the boot command interpreter in clocked mode, plus an asynchronous start-bit abort.
`timescale 1ns/1ps
module serial_boot_command_protocol_test;
	logic ref_clk;
	logic srst;
	logic [15:0] flash_sum;
	logic rxd, shift_clk, txd, boot_ready, mem_we, jump_en, boot_abort, sync_mode;
	logic [31:0] mem_addr, jump_addr;
	logic [7:0] mem_wdata;
	logic [39:0] wr_q[$];
	int error_cnt = 0;
	int checks = 0;
	serial_boot_command_protocol dut (.ref_clk(ref_clk), .srst(srst), .boot_serial_channel_rxd(rxd),
		.boot_serial_channel_txd(txd), .serial_shift_clock(shift_clk), .boot_ready(boot_ready),
		.flash_sum(flash_sum), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.jump_en(jump_en), .jump_addr(jump_addr), .boot_abort(boot_abort), .sync_mode(sync_mode));
	boot_host_model host (.ref_clk(ref_clk), .txd(txd), .boot_ready(boot_ready), .rxd(rxd),
		.shift_clk(shift_clk));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (mem_we) wr_q.push_back({mem_addr, mem_wdata});
	task automatic check(input string nm, input logic [39:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic xchg(input logic [7:0] b, exp, input string nm);
		logic [7:0] r;
		host.send_byte(b);
		host.recv_byte(r);
		check(nm, r, exp);
	endtask
	// Sends a field, then its checksum (one off when bad), then checks the answer.
	task automatic blk(input logic [7:0] d[$], input bit bad, input logic [7:0] ack, input string nm);
		logic [7:0] s = 8'h00;
		foreach (d[i]) begin
			host.send_byte(d[i]);
			s += d[i];
		end
		xchg(8'h00 - s + 8'(bad), ack, nm);
	endtask
	task automatic t_mode();
		host.half = 64;
		xchg(8'h30, 8'h30, "mode echo");
		check("sync_mode", sync_mode, 1'b1);
		host.half = 4;
		$display("t_mode done");
	endtask
	task automatic t_fsum(input logic [15:0] v);
		logic [7:0] r;
		logic [7:0] c;
		c = 8'h00 - v[15:8] - v[7:0];
		flash_sum = v;
		xchg(8'h20, 8'h20, "fsum ack");
		host.recv_byte(r);
		check("sum hi", r, v[15:8]);
		host.recv_byte(r);
		check("sum lo", r, v[7:0]);
		host.recv_byte(r);
		check("sum cks", r, c);
		$display("t_fsum done");
	endtask
	task automatic t_cmds();
		xchg(8'h40, 8'h41, "unknown cmd");
		xchg(8'h30, 8'h31, "info cmd");
		t_fsum(16'h00FF);
		$display("t_cmds done");
	endtask
	task automatic t_load();
		logic [7:0] pw[$];
		int n = 0;
		for (int i = 0; i < 12; i++) pw.push_back(8'(i * 19));
		xchg(8'h10, 8'h10, "load ack");
		blk(pw, 1'b0, 8'h10, "pass ack");
		// region at the bottom of on-chip RAM
		blk({8'hFF, 8'hFF, 8'h80, 8'h00, 8'h00, 8'h03}, 1'b1, 8'h11, "hdr nak");
		xchg(8'h10, 8'h10, "reload ack");
		blk(pw, 1'b0, 8'h10, "pass ack");
		blk({8'hFF, 8'hFF, 8'h80, 8'h00, 8'h00, 8'h03}, 1'b0, 8'h10, "hdr ack");
		wr_q.delete();
		blk({8'hA1, 8'hB2, 8'hC3}, 1'b0, 8'h10, "data ack");
		check("writes", wr_q.size(), 3);
		foreach (wr_q[i]) check("write", wr_q[i], {32'(32'hFFFF8000 + i), 8'(8'hA1 + 8'h11 * i)});
		while (jump_en !== 1'b1 && n < 400) begin
			host.tick(1);
			n++;
		end
		check("jump", {jump_en, jump_addr}, {1'b1, 32'hFFFF8000});
		$display("t_load done");
	endtask
	// Mid-run reset, then an asynchronous start bit too short to measure a rate.
	task automatic t_abort();
		host.tick(12);
		srst = 1'b1;
		host.tick(4);
		srst = 1'b0;
		host.tick(6);
		check("abort idle", boot_abort, 1'b0);
		host.rxd = 1'b0;
		host.tick(3);
		host.rxd = 1'b1;
		host.tick(10);
		check("abort", {boot_abort, sync_mode, txd}, 3'b101);
		$display("t_abort done");
	endtask
	initial begin
		srst = 1'b1;
		flash_sum = 16'h0000;
		repeat (4) @(posedge ref_clk);
		#1 srst = 1'b0;
		host.tick(4);
		t_mode();
		t_fsum(16'hA55A);
		t_cmds();
		t_load();
		t_abort();
		stop_test();
	end
	initial begin
		repeat (30000) @(posedge ref_clk);
		error_cnt++;
		stop_test();
	end
endmodule
